/* File: pmc_mgmt_station.sv */
`timescale 1ns/1ps
module pmc_mgmt_station (
  input  wire logic        sys_clk,
  input  wire logic        mgmt_ack,
  input  wire logic [15:0] mgmt_rdata,
  output logic             mgmt_req,
  output logic             mgmt_we,
  output logic [4:0]       mgmt_phy_addr,
  output logic [4:0]       mgmt_reg_addr,
  output logic [15:0]      mgmt_wdata
);
  // Idle bus at time zero
  initial begin
    mgmt_req = 1'b0;
    mgmt_we = 1'b0;
    mgmt_phy_addr = 5'h1f;
    mgmt_reg_addr = 5'h1f;
    mgmt_wdata = 16'hffff;
  end

  // One transfer: request for one edge, then look for the answer over two edges
  task automatic xfer(input logic we, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic got, output logic [15:0] rd);
    got = 1'b0;
    rd = 16'h0000;
    @(negedge sys_clk);
    mgmt_req = 1'b1;
    mgmt_we = we;
    mgmt_phy_addr = pa;
    mgmt_reg_addr = ra;
    mgmt_wdata = wd;
    @(negedge sys_clk);
    // Released lines carry the inverse so stale values never look valid
    mgmt_req = 1'b0;
    mgmt_we = ~we;
    mgmt_phy_addr = ~pa;
    mgmt_reg_addr = ~ra;
    mgmt_wdata = ~wd;
    repeat (2) begin
      if (!got && mgmt_ack === 1'b1) begin
        got = 1'b1;
        rd = mgmt_rdata;
      end
      @(negedge sys_clk);
    end
  endtask
endmodule

/* File: pmc_mode_cfg_regs.sv */
`timescale 1ns/1ps
`include "pmc_params.svh"
// Overview of operation
// - Bit 13 enables energy-detect power-down, resets 0
// - Energy bit clears after 256 ms silence
// - Energy bit set by hard reset, kept by soft
// - Loader rewrites special modes after reset, on reload
// - Bits 7:5 hold read/write operating mode
// - Bits 4:0 address; answer only matching transactions
// - Address also seeds transmit scrambler key
// - Port PHY reset restores soft-reset-immune bits
// - Basic-control soft reset keeps immune bits
// - Autoneg strap high gives mode 111
// - Otherwise mode is 0, speed, duplex straps
// - Straps latched when chip reset deasserts
// - Address default comes from address strap
// - Mode 000: 10 half, pattern 0000
// - Mode 001: 10 full, pattern 0001
// - Mode 010: 100 half, 1000, CRS tx+rx
// - Mode 011: 100 full, 1001, CRS rx
// - Mode 100: autoneg 100 half, 1100/0100
// - Mode 101: repeater, advertise 100 half, CRS rx
// - Mode 111: autoneg all abilities, adv 1111
module pmc_mode_cfg_regs
  import pmc_pkg::*;
#(
  parameter int unsigned ENERGY_TIMEOUT_CYC =
    (`PMC_CLK_HZ / 1000) * `PMC_ENERGY_TIMEOUT_MS,
  parameter int unsigned CNT_W = $clog2(ENERGY_TIMEOUT_CYC + 1)
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        autoneg_strap,
  input  wire logic        speed_strap,
  input  wire logic        duplex_strap,
  input  wire logic [4:0]  phy_addr_strap,
  input  wire logic        port_phy_rst,
  input  wire logic        phy_soft_rst,
  input  wire logic        line_energy_in,
  input  wire logic        reload_cmd,
  input  wire logic        loader_wr,
  input  wire logic [15:0] loader_wdata,
  input  wire logic        mgmt_req,
  input  wire logic        mgmt_we,
  input  wire logic [4:0]  mgmt_phy_addr,
  input  wire logic [4:0]  mgmt_reg_addr,
  input  wire logic [15:0] mgmt_wdata,
  output logic             mgmt_ack,
  output logic [15:0]      mgmt_rdata,
  output logic             loader_req,
  output logic             energy_detect_powerdown_en,
  output logic             line_energy_present,
  output logic [2:0]       phy_mode,
  output logic [4:0]       phy_bus_address,
  output logic [4:0]       scrambler_seed,
  output logic [3:0]       bc_force_bits,
  output logic [3:0]       bc_force_mask,
  output logic [3:0]       autoneg_advertisement,
  output logic             adv_valid,
  output logic             crs_on_tx,
  output logic             repeater_mode,
  output logic             power_down_mode
);

  // Elaboration check on the silence timer sizing
  if (ENERGY_TIMEOUT_CYC < 2 || CNT_W < 1 || CNT_W > 32 ||
      ENERGY_TIMEOUT_CYC >= (64'h1 << CNT_W)) begin : g_bad_tmo
    $error("pmc_mode_cfg_regs: bad timeout parameters");
  end

  localparam logic [CNT_W-1:0] TMO_LAST = CNT_W'(ENERGY_TIMEOUT_CYC - 1);

  // Strap default mode from latched straps
  function automatic logic [2:0] strap_mode(input logic an, input logic spd,
                                            input logic dpx);
    strap_mode = an ? `PMC_MODE_ALLCAP : {1'b0, spd, dpx};
  endfunction

  logic             rel_q;
  logic             an_strap_q;
  logic             spd_strap_q;
  logic             dpx_strap_q;
  logic [4:0]       addr_strap_q;
  logic             edpd_q;
  logic             energy_q;
  logic [CNT_W-1:0] idle_cnt_q;
  logic [2:0]       mode_q;
  logic [4:0]       addr_q;
  logic             mgmt_ack_q;
  logic [15:0]      mgmt_rdata_q;
  logic             loader_req_q;
  logic [3:0]       bc_bits_q;
  logic [3:0]       bc_mask_q;
  logic [3:0]       adv_q;
  logic             adv_valid_q;
  logic             crs_tx_q;
  logic             rep_q;
  logic             pwrdn_q;
  logic             hit;
  logic             wr_mcs;
  logic             wr_spm;

  // Transaction decode; only our address and our two registers
  assign hit = mgmt_req && (mgmt_phy_addr == addr_q) &&
               (mgmt_reg_addr == `PMC_REG_MODE_CTRL_STAT ||
                mgmt_reg_addr == `PMC_REG_SPECIAL_MODES);
  assign wr_mcs = hit && mgmt_we && (mgmt_reg_addr == `PMC_REG_MODE_CTRL_STAT);
  assign wr_spm = hit && mgmt_we && (mgmt_reg_addr == `PMC_REG_SPECIAL_MODES);

  // First cycle after reset release
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rel_q <= 1'b1;
    end else begin
      rel_q <= 1'b0;
    end
  end

  // Strap capture at reset release
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      an_strap_q   <= 1'b0;
      spd_strap_q  <= 1'b0;
      dpx_strap_q  <= 1'b0;
      addr_strap_q <= `PMC_ADDR_RST;
    end else if (rel_q) begin
      an_strap_q   <= autoneg_strap;
      spd_strap_q  <= speed_strap;
      dpx_strap_q  <= duplex_strap;
      addr_strap_q <= phy_addr_strap;
    end
  end

  // Energy-detect power-down enable
  always_ff @(posedge sys_clk) begin
    if (srst || port_phy_rst || phy_soft_rst) begin
      edpd_q <= `PMC_EDPD_RST;
    end else if (wr_mcs) begin
      edpd_q <= mgmt_wdata[`PMC_EDPD_BIT];
    end
  end

  // Line energy status and silence timer; soft reset leaves it alone
  always_ff @(posedge sys_clk) begin
    if (srst || port_phy_rst) begin
      energy_q   <= `PMC_ENERGY_RST;
      idle_cnt_q <= '0;
    end else if (line_energy_in) begin
      energy_q   <= 1'b1;
      idle_cnt_q <= '0;
    end else if (idle_cnt_q == TMO_LAST) begin
      energy_q   <= 1'b0;
    end else begin
      idle_cnt_q <= idle_cnt_q + 1'b1;
    end
  end

  // Special modes: strap defaults, port reset, loader, management write
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_q <= `PMC_MODE_RST;
      addr_q <= `PMC_ADDR_RST;
    end else if (rel_q) begin
      mode_q <= strap_mode(autoneg_strap, speed_strap, duplex_strap);
      addr_q <= phy_addr_strap;
    end else if (port_phy_rst) begin
      mode_q <= strap_mode(an_strap_q, spd_strap_q, dpx_strap_q);
      addr_q <= addr_strap_q;
    end else if (loader_wr) begin
      mode_q <= loader_wdata[`PMC_MODE_MSB:`PMC_MODE_LSB];
      addr_q <= loader_wdata[`PMC_ADDR_MSB:`PMC_ADDR_LSB];
    end else if (wr_spm) begin
      mode_q <= mgmt_wdata[`PMC_MODE_MSB:`PMC_MODE_LSB];
      addr_q <= mgmt_wdata[`PMC_ADDR_MSB:`PMC_ADDR_LSB];
    end
  end

  // Loader request after release and on reload
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      loader_req_q <= 1'b0;
    end else begin
      loader_req_q <= rel_q || reload_cmd;
    end
  end

  // Management answer; reserved bits read zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mgmt_ack_q   <= 1'b0;
      mgmt_rdata_q <= `PMC_ZERO16;
    end else begin
      mgmt_ack_q   <= hit;
      mgmt_rdata_q <= `PMC_ZERO16;
      if (hit && mgmt_reg_addr == `PMC_REG_MODE_CTRL_STAT) begin
        mgmt_rdata_q[`PMC_EDPD_BIT]   <= edpd_q;
        mgmt_rdata_q[`PMC_ENERGY_BIT] <= energy_q;
      end else if (hit) begin
        mgmt_rdata_q[`PMC_MODE_MSB:`PMC_MODE_LSB] <= mode_q;
        mgmt_rdata_q[`PMC_ADDR_MSB:`PMC_ADDR_LSB] <= addr_q;
      end
    end
  end

  // Mode decode onto control and advertisement patterns
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bc_bits_q   <= `PMC_BC_ALLCAP;
      bc_mask_q   <= `PMC_BC_MASK_AC;
      adv_q       <= `PMC_ADV_ALL;
      adv_valid_q <= 1'b1;
      crs_tx_q    <= 1'b1;
      rep_q       <= 1'b0;
      pwrdn_q     <= 1'b0;
    end else begin
      bc_bits_q   <= `PMC_NIBBLE0;
      bc_mask_q   <= `PMC_BC_MASK_ALL;
      adv_q       <= `PMC_NIBBLE0;
      adv_valid_q <= 1'b0;
      crs_tx_q    <= 1'b0;
      rep_q       <= 1'b0;
      pwrdn_q     <= 1'b0;
      case (mode_q)
        PMC_M_10HD: begin
          bc_bits_q <= `PMC_BC_10HD;
          crs_tx_q  <= 1'b1;
        end
        PMC_M_10FD: begin
          bc_bits_q <= `PMC_BC_10FD;
        end
        PMC_M_100HD: begin
          bc_bits_q <= `PMC_BC_100HD;
          crs_tx_q  <= 1'b1;
        end
        PMC_M_100FD: begin
          bc_bits_q <= `PMC_BC_100FD;
        end
        PMC_M_AN100HD: begin
          bc_bits_q   <= `PMC_BC_AN100;
          adv_q       <= `PMC_ADV_100HD;
          adv_valid_q <= 1'b1;
          crs_tx_q    <= 1'b1;
        end
        PMC_M_REPEAT: begin
          bc_bits_q   <= `PMC_BC_AN100;
          adv_q       <= `PMC_ADV_100HD;
          adv_valid_q <= 1'b1;
          rep_q       <= 1'b1;
        end
        PMC_M_PWRDN: begin
          bc_mask_q <= `PMC_NIBBLE0;
          pwrdn_q   <= 1'b1;
        end
        default: begin
          bc_bits_q   <= `PMC_BC_ALLCAP;
          bc_mask_q   <= `PMC_BC_MASK_AC;
          adv_q       <= `PMC_ADV_ALL;
          adv_valid_q <= 1'b1;
          crs_tx_q    <= 1'b1;
        end
      endcase
    end
  end

  // Scrambler seed registered again from the address; other registered state straight to the ports
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      scrambler_seed <= `PMC_ADDR_RST;
    end else begin
      scrambler_seed <= addr_q;
    end
  end

  assign mgmt_ack                   = mgmt_ack_q;
  assign mgmt_rdata                 = mgmt_rdata_q;
  assign loader_req                 = loader_req_q;
  assign energy_detect_powerdown_en = edpd_q;
  assign line_energy_present        = energy_q;
  assign phy_mode                   = mode_q;
  assign phy_bus_address            = addr_q;
  assign bc_force_bits              = bc_bits_q;
  assign bc_force_mask              = bc_mask_q;
  assign autoneg_advertisement      = adv_q;
  assign adv_valid                  = adv_valid_q;
  assign crs_on_tx                  = crs_tx_q;
  assign repeater_mode              = rep_q;
  assign power_down_mode            = pwrdn_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_mcs_write;
    wr_mcs && !port_phy_rst && !phy_soft_rst;
  endsequence
  sequence s_quiet;
    !port_phy_rst && !loader_wr && !wr_spm && !rel_q;
  endsequence

  a_edpd_write: assert property (s_mcs_write |=> edpd_q == $past(mgmt_wdata[`PMC_EDPD_BIT]))
    else $error("edpd bit did not follow write");
  a_energy_set: assert property (line_energy_in |=> energy_q)
    else $error("energy bit not set while energy present");
  a_energy_timeout: assert property ($fell(energy_q) |-> $past(idle_cnt_q) == TMO_LAST)
    else $error("energy bit cleared at wrong time");
  a_energy_soft_keep: assert property (phy_soft_rst && !port_phy_rst && !line_energy_in
      && idle_cnt_q != TMO_LAST |=> $stable(energy_q))
    else $error("soft reset changed energy bit");
  a_strap_default: assert property (rel_q |=> mode_q == $past(strap_mode(autoneg_strap,
      speed_strap, duplex_strap)) && addr_q == $past(phy_addr_strap))
    else $error("strap default not loaded at release");
  a_addr_filter: assert property (mgmt_req && mgmt_phy_addr != addr_q |=> !mgmt_ack)
    else $error("answered a foreign address");
  a_soft_keeps_mode: assert property ((phy_soft_rst and s_quiet) |=> $stable(mode_q)
      && $stable(addr_q) && !edpd_q)
    else $error("soft reset disturbed immune bits");
  a_port_rst_dflt: assert property (port_phy_rst && !rel_q |=> mode_q ==
      strap_mode(an_strap_q, spd_strap_q, dpx_strap_q) && addr_q == addr_strap_q)
    else $error("port reset did not restore defaults");
  a_loader_write: assert property (loader_wr && !port_phy_rst && !rel_q |=>
      {mode_q, addr_q} == $past(loader_wdata[`PMC_MODE_MSB:`PMC_ADDR_LSB]))
    else $error("loader write not taken");
  a_mode0_decode: assert property (mode_q == `PMC_MODE_10HD ##1 mode_q == `PMC_MODE_10HD
      |-> bc_force_bits == `PMC_BC_10HD && !adv_valid)
    else $error("mode 000 decode wrong");
  a_mode7_decode: assert property (mode_q == `PMC_MODE_ALLCAP |=>
      autoneg_advertisement == `PMC_ADV_ALL && adv_valid)
    else $error("mode 111 decode wrong");
  a_seed_follow: assert property (##1 scrambler_seed == $past(addr_q))
    else $error("scrambler seed not address");
  a_rsvd_zero: assert property (mgmt_ack |-> mgmt_rdata[15:14] == 2'h0
      && mgmt_rdata[12:8] == 5'h00)
    else $error("reserved bits read nonzero");

endmodule

/* File: pmc_params.svh */
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

// Management register indices
`define PMC_REG_MODE_CTRL_STAT 5'h11
`define PMC_REG_SPECIAL_MODES  5'h12

// Field positions
`define PMC_EDPD_BIT     13
`define PMC_ENERGY_BIT   1
`define PMC_MODE_MSB     7
`define PMC_MODE_LSB     5
`define PMC_ADDR_MSB     4
`define PMC_ADDR_LSB     0

// Reset values
`define PMC_EDPD_RST     1'h0
`define PMC_ENERGY_RST   1'h1
`define PMC_MODE_RST     3'h7
`define PMC_ADDR_RST     5'h00
`define PMC_ZERO16       16'h0000

// Mode codes
`define PMC_MODE_10HD    3'h0
`define PMC_MODE_10FD    3'h1
`define PMC_MODE_100HD   3'h2
`define PMC_MODE_100FD   3'h3
`define PMC_MODE_AN100HD 3'h4
`define PMC_MODE_REPEAT  3'h5
`define PMC_MODE_PWRDN   3'h6
`define PMC_MODE_ALLCAP  3'h7

// Basic-control pattern [13,12,10,8] and advertisement pattern [8,7,6,5]
`define PMC_BC_10HD      4'h0
`define PMC_BC_10FD      4'h1
`define PMC_BC_100HD     4'h8
`define PMC_BC_100FD     4'h9
`define PMC_BC_AN100     4'hc
`define PMC_BC_ALLCAP    4'h4
`define PMC_BC_MASK_ALL  4'hf
`define PMC_BC_MASK_AC   4'h6
`define PMC_ADV_100HD    4'h4
`define PMC_ADV_ALL      4'hf
`define PMC_NIBBLE0      4'h0

// Timing
`define PMC_CLK_HZ            10000000
`define PMC_ENERGY_TIMEOUT_MS 256

`endif

/* File: pmc_pkg.sv */
`include "pmc_params.svh"

package pmc_pkg;
  typedef enum logic [2:0] {
    PMC_M_10HD    = `PMC_MODE_10HD,
    PMC_M_10FD    = `PMC_MODE_10FD,
    PMC_M_100HD   = `PMC_MODE_100HD,
    PMC_M_100FD   = `PMC_MODE_100FD,
    PMC_M_AN100HD = `PMC_MODE_AN100HD,
    PMC_M_REPEAT  = `PMC_MODE_REPEAT,
    PMC_M_PWRDN   = `PMC_MODE_PWRDN,
    PMC_M_ALLCAP  = `PMC_MODE_ALLCAP
  } pmc_mode_e;
  typedef logic [15:0] pmc_word_t;
endpackage

/* File: tb_phy_mode_config_regs.sv */
`timescale 1ns/1ps
module tb_phy_mode_config_regs;
  import pmc_pkg::*;
  logic        sys_clk, srst, autoneg_strap, speed_strap, duplex_strap;
  logic [4:0]  phy_addr_strap, mgmt_phy_addr, mgmt_reg_addr, phy_bus_address, scrambler_seed;
  logic        port_phy_rst, phy_soft_rst, line_energy_in, reload_cmd, loader_wr;
  logic [15:0] loader_wdata, mgmt_wdata, mgmt_rdata;
  logic        mgmt_req, mgmt_we, mgmt_ack, loader_req, energy_detect_powerdown_en;
  logic        line_energy_present, adv_valid, crs_on_tx, repeater_mode, power_down_mode;
  logic [2:0]  phy_mode;
  logic [3:0]  bc_force_bits, bc_force_mask, autoneg_advertisement;
  logic [4:0]  my_addr;
  int          err_count, checks;
  localparam logic [3:0] BC_EXP [8] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hc, 4'hc, 4'h0, 4'h4};

  pmc_mode_cfg_regs #(.ENERGY_TIMEOUT_CYC(16)) uut (
    .sys_clk, .srst, .autoneg_strap, .speed_strap, .duplex_strap, .phy_addr_strap,
    .port_phy_rst, .phy_soft_rst, .line_energy_in, .reload_cmd, .loader_wr, .loader_wdata,
    .mgmt_req, .mgmt_we, .mgmt_phy_addr, .mgmt_reg_addr, .mgmt_wdata, .mgmt_ack,
    .mgmt_rdata, .loader_req, .energy_detect_powerdown_en, .line_energy_present, .phy_mode,
    .phy_bus_address, .scrambler_seed, .bc_force_bits, .bc_force_mask,
    .autoneg_advertisement, .adv_valid, .crs_on_tx, .repeater_mode, .power_down_mode
  );
  pmc_mgmt_station ms (
    .sys_clk, .mgmt_ack, .mgmt_rdata, .mgmt_req, .mgmt_we, .mgmt_phy_addr,
    .mgmt_reg_addr, .mgmt_wdata
  );

  // 100 ns clock
  always #50 sys_clk = ~sys_clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("Counts: checks=%0d errors=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic xfer_chk(input logic we, input logic [4:0] pa, input logic [4:0] ra,
                          input logic [15:0] wd, input logic ack_exp);
    logic        g;
    logic [15:0] d;
    ms.xfer(we, pa, ra, wd, g, d);
    chk({15'h0, g}, {15'h0, ack_exp});
  endtask

  task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp);
    logic        g;
    logic [15:0] d;
    ms.xfer(1'b0, my_addr, ra, 16'h0000, g, d);
    chk({15'h0, g}, 16'h0001);
    chk(d, exp);
  endtask

  // Loader request must pulse within a few cycles
  task automatic wait_lreq();
    logic seen;
    seen = 1'b0;
    repeat (5) begin
      if (loader_req === 1'b1) seen = 1'b1;
      @(negedge sys_clk);
    end
    chk({15'h0, seen}, 16'h0001);
  endtask

  task automatic do_reset(input logic an, input logic sp, input logic dp, input logic [4:0] pa);
    autoneg_strap = an;
    speed_strap = sp;
    duplex_strap = dp;
    phy_addr_strap = pa;
    my_addr = pa;
    srst = 1'b1;
    repeat (10) @(negedge sys_clk);
    srst = 1'b0;
    wait_lreq();
  endtask

  task automatic t_defaults(input logic [2:0] m);
    rd_chk(5'h12, {8'h00, m, my_addr});
    rd_chk(5'h11, 16'h0002);
    chk({11'h0, scrambler_seed}, {11'h0, my_addr});
  endtask

  task automatic t_edpd();
    xfer_chk(1'b1, my_addr, 5'h11, 16'hffff, 1'b1);
    rd_chk(5'h11, 16'h2002);
    chk({15'h0, energy_detect_powerdown_en}, 16'h0001);
    xfer_chk(1'b1, my_addr, 5'h11, 16'h0000, 1'b1);
    rd_chk(5'h11, 16'h0002);
  endtask

  // Foreign PHY address and unmapped index get no answer and change nothing
  task automatic t_refuse();
    xfer_chk(1'b1, my_addr ^ 5'h01, 5'h11, 16'h2000, 1'b0);
    xfer_chk(1'b1, my_addr, 5'h05, 16'h2000, 1'b0);
    xfer_chk(1'b1, my_addr ^ 5'h10, 5'h12, 16'h0000, 1'b0);
    rd_chk(5'h11, 16'h0002);
    rd_chk(5'h12, {8'h00, 3'h7, my_addr});
  endtask

  task automatic t_modes();
    logic [2:0] m;
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      xfer_chk(1'b1, my_addr, 5'h12, {8'hff, m, my_addr}, 1'b1);
      rd_chk(5'h12, {8'h00, m, my_addr});
      if (m != 3'h6) chk({12'h0, bc_force_bits & bc_force_mask}, {12'h0, BC_EXP[i]});
      chk({12'h0, bc_force_mask}, {12'h0, (m == 3'h7) ? 4'h6 : {4{m != 3'h6}}});
      chk({15'h0, adv_valid}, {15'h0, m >= 3'h4 && m != 3'h6});
      chk({15'h0, power_down_mode}, {15'h0, m == 3'h6});
      if (m >= 3'h4 && m != 3'h6)
        chk({12'h0, autoneg_advertisement}, (m == 3'h7) ? 16'h000f : 16'h0004);
      if (m >= 3'h2 && m <= 3'h5) chk({15'h0, crs_on_tx}, {15'h0, ~m[0]});
      chk({15'h0, repeater_mode}, {15'h0, m == 3'h5});
    end
  endtask

  task automatic t_energy();
    line_energy_in = 1'b1;
    repeat (3) @(negedge sys_clk);
    line_energy_in = 1'b0;
    repeat (12) @(negedge sys_clk);
    chk({15'h0, line_energy_present}, 16'h0001);
    repeat (8) @(negedge sys_clk);
    chk({15'h0, line_energy_present}, 16'h0000);
    rd_chk(5'h11, 16'h0000);
  endtask

  task automatic t_soft();
    xfer_chk(1'b1, my_addr, 5'h12, {8'h00, 3'h3, my_addr}, 1'b1);
    xfer_chk(1'b1, my_addr, 5'h11, 16'h2000, 1'b1);
    phy_soft_rst = 1'b1;
    @(negedge sys_clk);
    phy_soft_rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    rd_chk(5'h12, {8'h00, 3'h3, my_addr});
    chk({15'h0, line_energy_present}, 16'h0000);
    rd_chk(5'h11, 16'h0000);
  endtask

  // Straps move after reset; port reset must use the latched values
  task automatic t_port(input logic [2:0] m);
    autoneg_strap = ~autoneg_strap;
    speed_strap = ~speed_strap;
    phy_addr_strap = ~phy_addr_strap;
    port_phy_rst = 1'b1;
    @(negedge sys_clk);
    port_phy_rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk({15'h0, line_energy_present}, 16'h0001);
    rd_chk(5'h12, {8'h00, m, my_addr});
  endtask

  task automatic t_loader();
    reload_cmd = 1'b1;
    @(negedge sys_clk);
    reload_cmd = 1'b0;
    wait_lreq();
    loader_wr = 1'b1;
    loader_wdata = {8'h00, 3'h1, my_addr};
    @(negedge sys_clk);
    loader_wr = 1'b0;
    loader_wdata = ~loader_wdata;
    @(negedge sys_clk);
    chk({13'h0, phy_mode}, 16'h0001);
    chk({11'h0, phy_bus_address}, {11'h0, my_addr});
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #2000000;
    err_count++;
    end_sim();
  end

  initial begin
    sys_clk = 1'b0;
    srst = 1'b1;
    port_phy_rst = 1'b0;
    phy_soft_rst = 1'b0;
    line_energy_in = 1'b1;
    reload_cmd = 1'b0;
    loader_wr = 1'b0;
    loader_wdata = 16'h0000;
    err_count = 0;
    checks = 0;
    do_reset(1'b1, 1'b0, 1'b0, 5'h03);
    t_defaults(3'h7);
    t_edpd();
    t_refuse();
    t_modes();
    t_energy();
    t_soft();
    t_port(3'h7);
    t_loader();
    line_energy_in = 1'b1;
    do_reset(1'b0, 1'b1, 1'b0, 5'h0a);
    t_defaults(3'h2);
    t_port(3'h2);
    end_sim();
  end
endmodule
